// *** rtl/sbf_core.v ***
// satellite bus fault handling, otp, switch and reply serializer
`timescale 1ns/1ps
`include "sbf_defines.vh"
module sbf_core
#(
  parameter UV_POR_CYCLES = `SBF_UV_POR_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output wire irq,
  input wire rectified_supply_low,
  input wire regulated_supply_low,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [7:0] cmd_data,
  input wire cmd_on_downstream,
  input wire acc_sample_valid,
  input wire [9:0] acc_sample,
  input wire trim_prog_valid,
  input wire [6:0] trim_prog_index,
  input wire trim_factory_en,
  output reg upstream_bus_pin_out,
  output reg upstream_bus_pin_oe,
  output reg downstream_bus_pin_out,
  output reg downstream_bus_pin_oe,
  output reg pass_switch_closed
);

  // two-flop synchronisers for the supply comparators
  reg uv_meta_reg, uv_sync_reg, reg_meta_reg, reg_sync_reg;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      uv_meta_reg <= 1'b0;
      uv_sync_reg <= 1'b0;
      reg_meta_reg <= 1'b0;
      reg_sync_reg <= 1'b0;
    end
    else
    begin
      uv_meta_reg <= rectified_supply_low;
      uv_sync_reg <= uv_meta_reg;
      reg_meta_reg <= regulated_supply_low;
      reg_sync_reg <= reg_meta_reg;
    end
  end

  // sustained undervoltage timer and internal reset sequencing
  reg [31:0] uv_cnt_reg;
  reg por_hold_reg;
  reg [4:0] init_cnt_reg;
  reg active_reg;
  wire uv_expired;
  wire internal_rst;
  assign uv_expired = uv_sync_reg && (uv_cnt_reg >= UV_POR_CYCLES - 1); // R2
  assign internal_rst = reg_sync_reg || por_hold_reg; // R15

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      uv_cnt_reg <= 32'h0;
      por_hold_reg <= 1'b0;
      init_cnt_reg <= 5'h0;
      active_reg <= 1'b0;
    end
    else
    begin
      if (!uv_sync_reg)
        uv_cnt_reg <= 32'h0;
      else if (!uv_expired)
        uv_cnt_reg <= uv_cnt_reg + 32'h1;
      if (uv_expired)
        por_hold_reg <= 1'b1; // R2
      else if (!uv_sync_reg)
        por_hold_reg <= 1'b0; // R3
      if (internal_rst)
      begin
        init_cnt_reg <= 5'h0; // R15
        active_reg <= 1'b0;
      end
      else if (!active_reg)
      begin
        init_cnt_reg <= init_cnt_reg + 5'h1;
        if (init_cnt_reg == `SBF_INIT_CYCLES - 1)
          active_reg <= 1'b1; // R3
      end
    end
  end

  // otp memory; bus command or trim port may program it
  wire [127:0] otp_bits;
  wire fact_fault, cust_fault, parity_fault;
  reg tx_busy_reg;
  wire cmd_take;
  wire bus_prog;
  assign cmd_take = cmd_valid && active_reg && !tx_busy_reg;
  assign bus_prog = cmd_take && (cmd_code == `SBF_CMD_OTP_WRITE) &&
                    (cmd_data[6:0] >= `SBF_OTP_CUST_LO); // R8
  assign parity_fault = fact_fault || cust_fault; // R6

  sbf_otp u_otp
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .prog_valid(bus_prog || trim_prog_valid), // R8
    .prog_index(bus_prog ? cmd_data[6:0] : trim_prog_index),
    .prog_factory_en(!bus_prog && trim_factory_en),
    .otp_bits(otp_bits),
    .fact_parity_fault(fact_fault),
    .cust_parity_fault(cust_fault)
  );

  // reply width from control register: 8, 9 or 10 bits
  reg [1:0] ctrl_reg;
  reg [9:0] sample_reg;
  reg uv_flag_reg;
  reg reverse_reg;
  reg tx_down_reg;
  reg [11:0] tx_shift_reg;
  reg [3:0] tx_bits_reg;
  reg [2:0] tx_div_reg;
  reg drop_evt;
  wire is_read;
  wire [9:0] reply_data;
  wire [3:0] reply_len;

  function [9:0] fit_width;
    input [9:0] s;
    input [1:0] w;
    begin
      case (w)
        2'h0: fit_width = {2'h0, s[9:2]};
        2'h1: fit_width = {1'h0, s[9:1]};
        default: fit_width = s;
      endcase
    end
  endfunction

  // first reply bit to the top of the shift register
  function [11:0] left_align;
    input [11:0] w;
    input [3:0] n;
    begin
      left_align = w << (4'hC - n);
    end
  endfunction

  assign is_read = (cmd_code == `SBF_CMD_READ_SHORT) || (cmd_code == `SBF_CMD_READ_LONG);
  assign reply_data = fit_width(sample_reg, ctrl_reg); // R13
  assign reply_len = (ctrl_reg > 2'h2) ? 4'hA : (4'h8 + {2'h0, ctrl_reg});

  // command handling, flags, switch and serializer
  always @(posedge aclk)
  begin
    // commands refused while inactive or busy, internal reset included
    drop_evt <= aresetn && cmd_valid && !cmd_take;
    if (!aresetn || internal_rst)
    begin
      sample_reg <= 10'h0;
      uv_flag_reg <= 1'b0;
      reverse_reg <= 1'b0;
      pass_switch_closed <= 1'b0; // R9
      tx_busy_reg <= 1'b0;
      tx_down_reg <= 1'b0;
      tx_shift_reg <= 12'h0;
      tx_bits_reg <= 4'h0;
      tx_div_reg <= 3'h0;
    end
    else
    begin
      if (acc_sample_valid)
        sample_reg <= acc_sample;
      if (uv_sync_reg)
        uv_flag_reg <= 1'b1; // R1
      else if (cmd_take && cmd_code == `SBF_CMD_READ_LONG)
        uv_flag_reg <= 1'b0;
      if (cmd_take && (cmd_code == `SBF_CMD_INIT || cmd_code == `SBF_CMD_REV_INIT))
      begin
        reverse_reg <= (cmd_code == `SBF_CMD_REV_INIT); // R11
        if (cmd_data[`SBF_SWITCH_CLOSE_BIT])
          pass_switch_closed <= 1'b1; // R10
      end
      if (cmd_take && is_read)
      begin
        tx_busy_reg <= 1'b1;
        tx_down_reg <= cmd_on_downstream; // R11 R12
        tx_div_reg <= 3'h0;
        if (cmd_code == `SBF_CMD_READ_SHORT)
        begin
          // short word is zero on undervoltage or parity fault
          tx_shift_reg <= left_align({2'h0, (uv_sync_reg || uv_flag_reg || parity_fault) ?
                                     10'h0 : reply_data}, reply_len); // R1 R4
          tx_bits_reg <= reply_len;
        end
        else
        begin
          // long word appends undervoltage and parity status
          tx_shift_reg <= left_align({parity_fault ? 10'h0 : reply_data,
                                      uv_flag_reg | uv_sync_reg, parity_fault},
                                     reply_len + 4'h2); // R4
          tx_bits_reg <= reply_len + 4'h2;
        end
      end
      else if (tx_busy_reg)
      begin
        // one bit per bit period, most significant first
        if (tx_div_reg == `SBF_BIT_CYCLES - 1)
        begin
          tx_div_reg <= 3'h0;
          tx_shift_reg <= {tx_shift_reg[10:0], 1'b0}; // R14
          tx_bits_reg <= tx_bits_reg - 4'h1;
          if (tx_bits_reg == 4'h1)
            tx_busy_reg <= 1'b0;
        end
        else
          tx_div_reg <= tx_div_reg + 3'h1;
      end
    end
  end

  // pin drivers, silent whenever not transmitting
  always @(posedge aclk)
  begin
    if (!aresetn || internal_rst)
    begin
      upstream_bus_pin_out <= 1'b0;
      upstream_bus_pin_oe <= 1'b0; // R3 R15
      downstream_bus_pin_out <= 1'b0;
      downstream_bus_pin_oe <= 1'b0;
    end
    else
    begin
      upstream_bus_pin_oe <= tx_busy_reg && !tx_down_reg; // R12
      upstream_bus_pin_out <= tx_busy_reg && !tx_down_reg && tx_shift_reg[11]; // R14
      downstream_bus_pin_oe <= tx_busy_reg && tx_down_reg; // R11
      downstream_bus_pin_out <= tx_busy_reg && tx_down_reg && tx_shift_reg[11];
    end
  end

  // interrupt events
  reg prev_por_reg, prev_par_reg;
  wire [3:0] irq_evt;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_por_reg <= 1'b0;
      prev_par_reg <= 1'b0;
    end
    else
    begin
      prev_por_reg <= por_hold_reg;
      prev_par_reg <= parity_fault;
    end
  end
  assign irq_evt = {drop_evt, parity_fault && !prev_par_reg,
                    por_hold_reg && !prev_por_reg, uv_sync_reg};

  // axi4-lite slave: address and data taken in either order
  reg aw_have_reg, w_have_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [3:0] irq_status_reg, irq_mask_reg;
  wire wr_fire;
  wire rd_fire;
  wire rd_clr;
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_clr = rd_fire && (s_axi_araddr == `SBF_REG_IRQ_STATUS);
  assign irq = |(irq_status_reg & irq_mask_reg);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBF_AXI_OKAY;
      ctrl_reg <= `SBF_CTRL_RESET;
      irq_mask_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SBF_AXI_OKAY;
        case (aw_addr_reg)
          `SBF_REG_CTRL:
            if (w_strb_reg[0])
              ctrl_reg <= w_data_reg[1:0];
          `SBF_REG_IRQ_MASK:
            if (w_strb_reg[0])
              irq_mask_reg <= w_data_reg[3:0];
          `SBF_REG_STATUS, `SBF_REG_IRQ_STATUS:
            s_axi_bresp <= `SBF_AXI_OKAY;
          default:
            s_axi_bresp <= (aw_addr_reg >= `SBF_REG_OTP0 && aw_addr_reg <= `SBF_REG_OTP3 &&
                            aw_addr_reg[1:0] == 2'h0) ? `SBF_AXI_OKAY : `SBF_AXI_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // sticky interrupt status; a new event beats the read clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_reg <= 4'h0;
    else
      irq_status_reg <= (rd_clr ? 4'h0 : irq_status_reg) | irq_evt;
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SBF_AXI_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SBF_AXI_OKAY;
      case (s_axi_araddr)
        `SBF_REG_CTRL: s_axi_rdata <= {30'h0, ctrl_reg};
        `SBF_REG_STATUS: s_axi_rdata <= {25'h0, tx_busy_reg, reverse_reg, pass_switch_closed,
                                         active_reg, cust_fault, fact_fault, uv_flag_reg};
        `SBF_REG_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status_reg};
        `SBF_REG_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_reg};
        8'h10: s_axi_rdata <= otp_bits[31:0];
        8'h14: s_axi_rdata <= otp_bits[63:32];
        8'h18: s_axi_rdata <= otp_bits[95:64];
        `SBF_REG_OTP3: s_axi_rdata <= otp_bits[127:96];
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `SBF_AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // sbf_core

// *** rtl/sbf_defines.vh ***
// constants of the satellite bus fault and otp logic
// How it works
// R1: rectified supply low zeroes short acceleration replies and sets undervoltage flag.
// R2: undervoltage lasting over one millisecond fires the internal power-on reset.
// R3: after that reset, stay silent until supply returns and initialization ends.
// R4: any otp parity fault makes every acceleration read answer zero.
// R5: otp parity is checked every cycle during operation.
// R6: factory and customer regions each carry and check their own parity bit.
// R7: 128 otp bits held, eighty of them in the customer region.
// R8: customer region written by bus command or by the trim interface.
// R9: every reset leaves the pass-through switch open.
// R10: init or reverse init with switch close request bit set closes the switch.
// R11: reverse init moves master traffic to the downstream pin; here it only sets reverse_reg, replies follow cmd_on_downstream.
// R12: normally commands come in and replies go out on the upstream pin.
// R13: 10-bit samples replied as eight, nine or ten data bits.
// R14: reply word is shifted out serially on the bus pin.
// R15: regulated supply low holds the device in reset, transmitting nothing.
`ifndef SBF_DEFINES_VH
`define SBF_DEFINES_VH
// clock and timing
`define SBF_CLK_HZ 10000000
`define SBF_UV_POR_TIME_US 1000
`define SBF_UV_POR_CYCLES (`SBF_UV_POR_TIME_US * (`SBF_CLK_HZ / 1000000))
`define SBF_INIT_CYCLES 16
`define SBF_BIT_CYCLES 4
// otp layout
`define SBF_OTP_BITS 128
`define SBF_OTP_CUST_BITS 80
`define SBF_OTP_FACT_PAR 47
`define SBF_OTP_CUST_LO 48
`define SBF_OTP_CUST_PAR 127
// bus commands
`define SBF_CMD_INIT 4'h0
`define SBF_CMD_REV_INIT 4'h1
`define SBF_CMD_READ_SHORT 4'h2
`define SBF_CMD_READ_LONG 4'h3
`define SBF_CMD_OTP_WRITE 4'h4
`define SBF_SWITCH_CLOSE_BIT 6
// register offsets
`define SBF_REG_CTRL 8'h00
`define SBF_REG_STATUS 8'h04
`define SBF_REG_IRQ_STATUS 8'h08
`define SBF_REG_IRQ_MASK 8'h0C
`define SBF_REG_OTP0 8'h10
`define SBF_REG_OTP3 8'h1C
// field positions and resets
`define SBF_CTRL_RESET 2'h2
`define SBF_IRQ_UV 0
`define SBF_IRQ_POR 1
`define SBF_IRQ_PARITY 2
`define SBF_IRQ_DROP 3
`define SBF_IRQ_WIDTH 4
`define SBF_AXI_OKAY 2'h0
`define SBF_AXI_SLVERR 2'h2
`endif

// *** rtl/sbf_otp.v ***
// one-time-programmable memory with per-region parity checking
`timescale 1ns/1ps
`include "sbf_defines.vh"
module sbf_otp
(
  input wire aclk,
  input wire aresetn,
  input wire prog_valid,
  input wire [6:0] prog_index,
  input wire prog_factory_en,
  output wire [127:0] otp_bits,
  output wire fact_parity_fault,
  output wire cust_parity_fault
);

  reg [127:0] otp_reg;
  wire cust_index;

  // customer region starts above the factory parity bit
  assign cust_index = (prog_index >= `SBF_OTP_CUST_LO); // R7
  assign otp_bits = otp_reg;

  // fuses only blow from zero to one; factory area needs the trim unlock
  always @(posedge aclk)
  begin
    if (!aresetn)
      otp_reg <= 128'h0;
    else if (prog_valid && (cust_index || prog_factory_en))
      otp_reg[prog_index] <= 1'b1; // R8
  end

  // each region checked against its own even parity, every cycle
  assign fact_parity_fault = ^otp_reg[`SBF_OTP_FACT_PAR:0]; // R5 R6
  assign cust_parity_fault = ^otp_reg[`SBF_OTP_CUST_PAR:`SBF_OTP_CUST_LO]; // R5 R6

endmodule // sbf_otp

// *** test/sbf_bus_master.sv ***
// sensor bus master model: sends commands, collects serial replies
`timescale 1ns/1ps
module sbf_bus_master (
  input wire aclk,
  output reg cmd_valid = 1'b0,
  output reg [3:0] cmd_code = 4'h0,
  output reg [7:0] cmd_data = 8'h00,
  output reg cmd_on_downstream = 1'b0,
  input wire upstream_bus_pin_out,
  input wire upstream_bus_pin_oe,
  input wire downstream_bus_pin_out,
  input wire downstream_bus_pin_oe,
  output reg rx_done = 1'b0,
  output reg rx_dn = 1'b0,
  output reg [3:0] rx_bits = 4'h0,
  output reg [11:0] rx_word = 12'h000
);
  reg [7:0] cnt_reg = 8'h00;
  reg [11:0] sh_reg = 12'h000;
  wire oe = upstream_bus_pin_oe | downstream_bus_pin_oe;
  wire pin = upstream_bus_pin_oe ? upstream_bus_pin_out : downstream_bus_pin_out;
  // one command pulse, payload scrambled between commands
  task send(input [3:0] c, input [7:0] d, input dn);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    cmd_on_downstream <= dn;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_data <= ~d;
    cmd_on_downstream <= ~dn;
  endtask
  // listen on whichever pin drives, sample mid bit
  always @(posedge aclk)
  begin
    rx_done <= 1'b0;
    if (oe)
    begin
      cnt_reg <= cnt_reg + 8'h01;
      rx_dn <= downstream_bus_pin_oe;
      if (cnt_reg[1:0] == 2'h1)
        sh_reg <= {sh_reg[10:0], pin};
    end
    else if (cnt_reg != 8'h00)
    begin
      rx_done <= 1'b1;
      rx_word <= sh_reg;
      rx_bits <= cnt_reg[5:2];
      cnt_reg <= 8'h00;
      sh_reg <= 12'h000;
    end
  end
endmodule // sbf_bus_master

// *** test/sbf_core_props.sv ***
// assertions on the fault and reply pins of the core
`timescale 1ns/1ps
`include "sbf_defines.vh"
module sbf_core_props #(parameter UV_POR_CYCLES = 10000) (
  input wire aclk,
  input wire aresetn,
  input wire rectified_supply_low,
  input wire regulated_supply_low,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [7:0] cmd_data,
  input wire upstream_bus_pin_out,
  input wire upstream_bus_pin_oe,
  input wire downstream_bus_pin_out,
  input wire downstream_bus_pin_oe,
  input wire pass_switch_closed
);
  wire oe = upstream_bus_pin_oe | downstream_bus_pin_oe;
  reg [15:0] uv_reg;
  reg [7:0] oe_reg;
  reg [5:0] up_reg;
  // run lengths of undervoltage, transmit and time since reset
  always @(posedge aclk)
  begin
    uv_reg <= (aresetn && rectified_supply_low) ? uv_reg + 16'h0001 : 16'h0000;
    oe_reg <= (aresetn && oe) ? oe_reg + 8'h01 : 8'h00;
    up_reg <= !aresetn ? 6'h00 : up_reg + {5'h00, ~&up_reg};
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_open; $rose(aresetn) |-> !pass_switch_closed; endproperty
  a_open: assert property (p_open) else $error("switch closed after reset");
  property p_init; up_reg < 6'h10 |-> !oe; endproperty
  a_init: assert property (p_init) else $error("reply before init done");
  property p_sust; uv_reg > UV_POR_CYCLES + 8 |-> !oe; endproperty
  a_sust: assert property (p_sust) else $error("reply in sustained undervoltage");
  property p_creg; regulated_supply_low [*5] |-> !oe; endproperty
  a_creg: assert property (p_creg) else $error("reply while regulator low");
  property p_uvz;
    rectified_supply_low [*4] ##0 (cmd_valid && cmd_code == `SBF_CMD_READ_SHORT)
      |-> ##2 (!upstream_bus_pin_out && !downstream_bus_pin_out) [*8];
  endproperty
  a_uvz: assert property (p_uvz) else $error("short reply not zero");
  property p_sw;
    cmd_valid && cmd_code[3:1] == 3'h0 && cmd_data[`SBF_SWITCH_CLOSE_BIT] && !oe
      && up_reg == 6'h3F && uv_reg == 16'h0000 && !regulated_supply_low
      |-> ##[1:3] pass_switch_closed;
  endproperty
  a_sw: assert property (p_sw) else $error("switch did not close");
  property p_pin; !(upstream_bus_pin_oe && downstream_bus_pin_oe); endproperty
  a_pin: assert property (p_pin) else $error("both pins driven");
  property p_len; $fell(oe) |-> oe_reg inside {32, 36, 40, 44, 48}; endproperty
  a_len: assert property (p_len) else $error("reply length wrong");
  c_long: cover property (cmd_valid && cmd_code == `SBF_CMD_READ_LONG);
  c_rev: cover property ($rose(downstream_bus_pin_oe));
  c_sw: cover property ($rose(pass_switch_closed));
endmodule // sbf_core_props
bind sbf_core sbf_core_props #(.UV_POR_CYCLES(UV_POR_CYCLES)) i_sbf_core_props (.*);

// *** test/sbf_core_tb.sv ***
// self-checking bench for the core against a reply model
`timescale 1ns/1ps
`include "sbf_defines.vh"
module sbf_core_tb;
  localparam int UV = 200;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] rr;
  logic rectified_supply_low = 1'b0, regulated_supply_low = 1'b0, acc_sample_valid = 1'b0;
  logic trim_prog_valid = 1'b0, trim_factory_en = 1'b0;
  logic [9:0] acc_sample = 10'h000;
  logic [6:0] trim_prog_index = 7'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cmd_valid, cmd_on_downstream, rx_done, rx_dn, pass_switch_closed;
  wire [3:0] cmd_code, rx_bits;
  wire [7:0] cmd_data;
  wire [11:0] rx_word;
  wire upstream_bus_pin_out, upstream_bus_pin_oe, downstream_bus_pin_out, downstream_bus_pin_oe;
  int n_fail = 0, check_count = 0, wid = 2, smp = 0, uf = 0, pf = 0;
  sbf_core #(.UV_POR_CYCLES(UV)) i_sbf_core (.*);
  sbf_bus_master i_sbf_bus_master (.*);
  initial forever #50 aclk = ~aclk;
  task test_done;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tmo(input int n);
    if (n > 98)
    begin
      n_fail++;
      test_done;
    end
  endtask
  // bus write, address and data offered together
  task wr(input [7:0] a, input [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 99);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  // bus read, masked compare
  task rk(input [7:0] a, input [31:0] m, input [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 99);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
    if (m != 0) chk(rv & m, e);
  endtask
  task act;
    int n;
    n = 0;
    do
    begin
      rk(`SBF_REG_STATUS, 0, 0);
      n++;
    end
    while (rv[3] !== 1'b1 && n < 99);
    tmo(n);
  endtask
  task cm(input [3:0] c, input [7:0] d, input dn);
    @(posedge aclk);
    i_sbf_bus_master.send(c, d, dn);
  endtask
  // read command, reply checked against the model
  task rq(input [3:0] c, input dn);
    int n, len, dat;
    logic [11:0] ew;
    logic [3:0] eb;
    n = 0;
    len = (wid == 0) ? 8 : (wid == 1) ? 9 : 10;
    dat = smp >> (10 - len);
    ew = (uf || pf) ? 0 : dat;
    eb = len;
    if (c == `SBF_CMD_READ_LONG)
    begin
      ew = ((pf ? 0 : dat) << 2) | (uf << 1) | pf;
      eb = len + 2;
      if (!rectified_supply_low) uf = 0;
    end
    cm(c, 8'h00, dn);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (!rx_done && n < 99);
    tmo(n);
    chk(rx_word, ew);
    chk(rx_bits, eb);
    chk(rx_dn, dn);
  endtask
  task trim(input [6:0] i, input f);
    @(posedge aclk);
    trim_prog_valid <= 1'b1;
    trim_prog_index <= i;
    trim_factory_en <= f;
    @(posedge aclk);
    trim_prog_valid <= 1'b0;
    trim_factory_en <= 1'b0;
  endtask
  initial
  begin
    void'($urandom(32'h3B65B1F0));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rk(`SBF_REG_CTRL, 32'hFFFFFFFF, 32'h2);
    rk(`SBF_REG_STATUS, 32'h10, 0);
    act;
    for (int w = 0; w < 3; w++)
    begin
      wid = w;
      wr(`SBF_REG_CTRL, w);
      smp = $urandom % 1024;
      acc_sample <= smp[9:0];
      acc_sample_valid <= 1'b1;
      @(posedge aclk);
      acc_sample_valid <= 1'b0;
      rq(`SBF_CMD_READ_SHORT, 0);
    end
    rq(`SBF_CMD_READ_LONG, 0);
    rectified_supply_low <= 1'b1;
    repeat (6) @(posedge aclk);
    uf = 1;
    rq(`SBF_CMD_READ_SHORT, 0);
    rk(`SBF_REG_STATUS, 1, 1);
    chk(irq, 0);
    wr(`SBF_REG_IRQ_MASK, 1);
    chk(irq, 1);
    rectified_supply_low <= 1'b0;
    repeat (4) @(posedge aclk);
    rk(`SBF_REG_IRQ_STATUS, 32'hF, 1);
    rk(`SBF_REG_IRQ_STATUS, 32'hF, 0);
    chk(irq, 0);
    rq(`SBF_CMD_READ_LONG, 0);
    rq(`SBF_CMD_READ_SHORT, 0);
    cm(`SBF_CMD_INIT, 8'h40, 0);
    repeat (3) @(posedge aclk);
    chk(pass_switch_closed, 1);
    cm(`SBF_CMD_REV_INIT, 8'h00, 1);
    rk(`SBF_REG_STATUS, 32'h30, 32'h30);
    rq(`SBF_CMD_READ_SHORT, 1);
    cm(`SBF_CMD_OTP_WRITE, 8'd50, 0);
    cm(`SBF_CMD_OTP_WRITE, 8'd10, 0);
    pf = 1;
    rk(`SBF_REG_STATUS, 32'h6, 32'h4);
    rk(`SBF_REG_OTP0, 32'hFFFFFFFF, 0);
    rk(`SBF_REG_OTP0 + 8'h04, 32'hFFFFFFFF, 32'h40000);
    rq(`SBF_CMD_READ_SHORT, 0);
    rq(`SBF_CMD_READ_LONG, 0);
    trim(7'd127, 1'b0);
    pf = 0;
    rk(`SBF_REG_STATUS, 32'h6, 0);
    trim(7'd3, 1'b1);
    pf = 1;
    rk(`SBF_REG_STATUS, 32'h6, 32'h2);
    rq(`SBF_CMD_READ_SHORT, 0);
    rectified_supply_low <= 1'b1;
    repeat (UV + 20) @(posedge aclk);
    rk(`SBF_REG_STATUS, 32'h18, 0);
    rk(`SBF_REG_IRQ_STATUS, 32'h2, 32'h2);
    chk(pass_switch_closed, 0);
    rectified_supply_low <= 1'b0;
    act;
    rq(`SBF_CMD_READ_SHORT, 0);
    regulated_supply_low <= 1'b1;
    repeat (5) @(posedge aclk);
    rk(`SBF_REG_STATUS, 32'h8, 0);
    cm(`SBF_CMD_READ_SHORT, 8'h00, 0);
    rk(`SBF_REG_IRQ_STATUS, 32'h8, 32'h8);
    regulated_supply_low <= 1'b0;
    act;
    rk(8'h40, 32'hFFFFFFFF, 0);
    chk(rr, `SBF_AXI_SLVERR);
    test_done;
  end
endmodule // sbf_core_tb
